// ==== pkg/timer_counter_regs.vh ====
/*
 Register offsets, field positions, reset values and timing counts of the 8/16-bit timer/counter.
 Assumes it is included by bare name from the design files and holds definitions only.
*/
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH

// Register offsets on the 3-bit register address
`define OFS_COUNT_LOW 3'h0
`define OFS_COUNT_HIGH 3'h1
`define OFS_CONTROL_A 3'h2
`define OFS_CONTROL_B 3'h3
`define OFS_STATUS 3'h4

// control_reg_a fields
`define CA_ENABLE_BIT 7
`define CA_OUTPUT_BIT 5
`define CA_WIDTH_BIT 4
`define CA_POST_MSB 3
`define CA_POST_LSB 0

// control_reg_b fields
`define CB_SRC_MSB 7
`define CB_SRC_LSB 5
`define CB_ASYNC_BIT 4
`define CB_PRE_MSB 3
`define CB_PRE_LSB 0

// status register fields
`define ST_FLAG_BIT 0

// Reset values
`define RST_COUNT_LOW 8'h00
`define RST_COUNT_HIGH 8'hFF
`define RST_CONTROL_A 8'h00
`define RST_CONTROL_B 8'h00

// Clock source codes
`define SRC_PIN_TRUE 3'h0
`define SRC_PIN_INV 3'h1
`define SRC_SYS_DIV4 3'h2

// Instruction cycle is the system clock divided by this
`define SYS_DIV 4
`define SYS_DIV_LAST 2'h3

`endif

// ==== verilog/pin_edge_sync.v ====
/*
 Three-stage synchroniser with agreement filter and rising-edge pulse.
 Assumes the input may change at any time relative to clk_sys.
*/
module pin_edge_sync (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Asynchronous level in
	input wire pin_in,
	// Filtered level and its rising edge
	output reg level_q,
	output reg rise_q
);

reg s1_q;
reg s2_q;
reg s3_q;

// First stage feeds only the second
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		s1_q <= 1'b0;
		s2_q <= 1'b0;
		s3_q <= 1'b0;
		level_q <= 1'b0;
		rise_q <= 1'b0;
	end else begin
		s1_q <= pin_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
		rise_q <= 1'b0;
		// A change counts once stages two and three agree
		if (s2_q == s3_q) begin
			level_q <= s2_q;
			rise_q <= s2_q & ~level_q;
		end
	end
end

endmodule

// ==== verilog/timer_counter.v ====
/*
 8/16-bit timer/counter with prescaler, postscaler, buffered 16-bit access and period match.
 Assumes a register master on clk_sys with one-cycle strobes and external count pins from any domain.
*/
// Our own choices: strobed register access and the address map.
// What this block does
// [R1] One bit selects 8-bit or 16-bit counting
// [R2] Count rises after programmable 15-bit prescaler
// [R3] Low read copies live high into buffer
// [R4] Low write loads high from buffer atomically
// [R5] 8-bit match: pulse output, clear, reload period
// [R6] 8-bit: bytes read/write; reset low 0, high FF
// [R7] Low or control writes clear both scalers
// [R8] Counter mode: each input or prescaler edge +1
// [R9] Timer mode: one count per instruction cycle
// [R10] Async mode counts unsynchronised, also in sleep
// [R11] Sync mode aligns counting to instruction cycle
// [R12] Sync count clock must not exceed sysclk/4
// [R13] 3-bit field selects clock source
// [R14] Internal source: timer counts prescaled clock
// [R15] External source: counts prescaled rising edges
// [R16] Sixteen power-of-two prescales, software cannot see
// [R17] Postscaler 1:1 to 1:16, software cannot see
// [R18] Software accounts prescale and postscale in period
// [R19] Flag on 8-bit match or 16-bit rollover
// [R20] Flag every postscale-plus-one events
// [R21] Output toggles on each postscaled event
// [R22] Enable bit runs or stops the timer
// [R23] Disabled timer holds count, makes no events

`include "timer_counter_regs.vh"

module timer_counter #(
	parameter PRE_W = 15,
	parameter AUX_N = 5
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Register port
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	// Count inputs
	input wire count_pin,
	input wire [AUX_N-1:0] aux_clk_in,
	input wire sleep,
	// Timer outputs
	output reg timer_output_q,
	output reg period_pulse_q,
	output reg timer_event_flag_q
);

////////////////////////////////////////////////////////////////////////////////

reg [7:0] count_low_q;
reg [7:0] count_high_q;
reg [7:0] count_high_buffer_q;
reg [7:0] period_buf_q;
reg [7:0] control_reg_a_q;
reg [7:0] control_reg_b_q;
reg [PRE_W-1:0] pre_cnt_q;
reg [3:0] post_cnt_q;
reg [1:0] div_q;
reg pending_q;

wire module_enable;
wire width_select;
wire async_enable;
wire [3:0] postscale_select;
wire [3:0] prescale_select;
wire [2:0] clock_source_select;

assign module_enable = control_reg_a_q[`CA_ENABLE_BIT];
assign width_select = control_reg_a_q[`CA_WIDTH_BIT];
assign postscale_select = control_reg_a_q[`CA_POST_MSB:`CA_POST_LSB];
assign clock_source_select = control_reg_b_q[`CB_SRC_MSB:`CB_SRC_LSB];
assign async_enable = control_reg_b_q[`CB_ASYNC_BIT];
assign prescale_select = control_reg_b_q[`CB_PRE_MSB:`CB_PRE_LSB];

wire wr_low;
wire wr_high;
wire wr_ctl_a;
wire wr_ctl_b;
wire wr_status;
wire rd_low;

assign wr_low = reg_wr & (reg_addr == `OFS_COUNT_LOW);
assign wr_high = reg_wr & (reg_addr == `OFS_COUNT_HIGH);
assign wr_ctl_a = reg_wr & (reg_addr == `OFS_CONTROL_A);
assign wr_ctl_b = reg_wr & (reg_addr == `OFS_CONTROL_B);
assign wr_status = reg_wr & (reg_addr == `OFS_STATUS);
assign rd_low = reg_rd & (reg_addr == `OFS_COUNT_LOW);

// Any of these restarts both scalers
wire scaler_clear;
assign scaler_clear = wr_low | wr_ctl_a | wr_ctl_b; // see [R7]

////////////////////////////////////////////////////////////////////////////////
// Clock source selection

// Instruction-cycle strobe from the system clock
wire quarter;
assign quarter = (div_q == `SYS_DIV_LAST);

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		div_q <= 2'h0;
	end else begin
		div_q <= div_q + 2'h1;
	end
end

// Pin or auxiliary source, inversion applied ahead of the synchroniser
reg ext_raw;
always @* begin
	case (clock_source_select) // see [R13]
		`SRC_PIN_TRUE: ext_raw = count_pin;
		`SRC_PIN_INV: ext_raw = ~count_pin;
		`SRC_SYS_DIV4: ext_raw = 1'b0;
		default: ext_raw = aux_clk_in[clock_source_select - 3'h3];
	endcase
end

wire ext_rise;
pin_edge_sync u_src_sync (
	.clk_sys(clk_sys),
	.rst(rst),
	.pin_in(ext_raw),
	.level_q(),
	.rise_q(ext_rise)
);

// Source edge before the prescaler
wire src_edge;
assign src_edge = (clock_source_select == `SRC_SYS_DIV4) ? quarter : ext_rise; // see [R14] [R15]

// Sync mode halts in sleep; async keeps counting while its source runs
wire run;
assign run = module_enable & (async_enable | ~sleep); // see [R10] [R22]

////////////////////////////////////////////////////////////////////////////////
// Prescaler

// Low bits selected by the ratio; all ones means this edge completes a period
reg [PRE_W-1:0] pre_mask;
integer i;
always @* begin
	pre_mask = {PRE_W{1'b0}};
	for (i = 0; i < PRE_W; i = i + 1) begin
		if (i < prescale_select) begin
			pre_mask[i] = 1'b1; // see [R16]
		end
	end
end

wire pre_tick;
assign pre_tick = run & src_edge & ((pre_cnt_q & pre_mask) == pre_mask); // see [R2] [R8]

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		pre_cnt_q <= {PRE_W{1'b0}};
	end else if (scaler_clear | ~module_enable) begin
		pre_cnt_q <= {PRE_W{1'b0}}; // see [R7]
	end else if (run & src_edge) begin
		if ((pre_cnt_q & pre_mask) == pre_mask) begin
			pre_cnt_q <= {PRE_W{1'b0}};
		end else begin
			pre_cnt_q <= pre_cnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Synchronous alignment

// A prescaled edge off the strobe waits for the next instruction-cycle strobe; one on a strobe counts there and again at the next
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		pending_q <= 1'b0;
	end else if (scaler_clear | ~module_enable) begin
		pending_q <= 1'b0;
	end else if (quarter) begin
		pending_q <= pre_tick & ~async_enable;
	end else if (pre_tick & ~async_enable) begin
		pending_q <= 1'b1;
	end
end

// Edges faster than the strobe merge, so only one count per instruction cycle
wire count_tick;
assign count_tick = async_enable ? pre_tick : (run & quarter & (pending_q | pre_tick)); // see [R9] [R10] [R11] [R12]

////////////////////////////////////////////////////////////////////////////////
// Counter

wire low_full;
wire high_full;
wire period_hit;
assign low_full = (count_low_q == 8'hFF);
assign high_full = (count_high_q == 8'hFF);
assign period_hit = (count_low_q == period_buf_q); // see [R5]

// Match in 8-bit mode, wrap from all ones in 16-bit mode
wire count_event;
assign count_event = count_tick & (width_select ? (low_full & high_full) : period_hit); // see [R19] [R23]

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		count_low_q <= `RST_COUNT_LOW; // see [R6]
		count_high_q <= 8'h00;
		period_buf_q <= `RST_COUNT_HIGH;
	end else if (wr_low) begin
		// Software write takes precedence over a count in the same cycle
		count_low_q <= reg_wdata; // see [R6]
		if (width_select) begin
			count_high_q <= count_high_buffer_q; // see [R4]
		end
	end else if (count_tick) begin
		if (width_select) begin
			count_low_q <= count_low_q + 8'h01; // see [R1]
			if (low_full) begin
				count_high_q <= count_high_q + 8'h01;
			end
		end else if (period_hit) begin
			count_low_q <= 8'h00; // see [R5]
			period_buf_q <= count_high_buffer_q;
		end else begin
			count_low_q <= count_low_q + 8'h01; // see [R1]
		end
	end
end

// High register: 16-bit buffer, or the period value in 8-bit mode
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		count_high_buffer_q <= `RST_COUNT_HIGH; // see [R6]
	end else if (wr_high) begin
		count_high_buffer_q <= reg_wdata; // see [R4] [R6]
	end else if (rd_low & width_select) begin
		count_high_buffer_q <= count_high_q; // see [R3]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Postscaler, flag and output

wire post_event;
assign post_event = count_event & (post_cnt_q == postscale_select); // see [R17] [R20]

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		post_cnt_q <= 4'h0;
	end else if (scaler_clear | ~module_enable) begin
		post_cnt_q <= 4'h0; // see [R7]
	end else if (count_event) begin
		if (post_cnt_q == postscale_select) begin
			post_cnt_q <= 4'h0; // see [R20]
		end else begin
			post_cnt_q <= post_cnt_q + 4'h1;
		end
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		timer_event_flag_q <= 1'b0;
		timer_output_q <= 1'b0;
		period_pulse_q <= 1'b0;
	end else begin
		// New event wins over a clear in the same cycle
		if (post_event) begin
			timer_event_flag_q <= 1'b1; // see [R19] [R20]
		end else if (wr_status & reg_wdata[`ST_FLAG_BIT]) begin
			timer_event_flag_q <= 1'b0;
		end
		if (post_event) begin
			timer_output_q <= ~timer_output_q; // see [R21]
		end
		// High from the event until the next prescaled count
		if (post_event) begin
			period_pulse_q <= 1'b1; // see [R5]
		end else if (count_tick | ~module_enable) begin
			period_pulse_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		control_reg_a_q <= `RST_CONTROL_A;
		control_reg_b_q <= `RST_CONTROL_B;
	end else begin
		if (wr_ctl_a) begin
			// Output bit is read-only and bit 6 unimplemented
			control_reg_a_q <= {reg_wdata[7], 2'b00, reg_wdata[4:0]};
		end
		if (wr_ctl_b) begin
			control_reg_b_q <= reg_wdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port

// Scaler counts are never visible here
reg [7:0] rd_mux;
always @* begin
	case (reg_addr) // see [R16] [R17]
		`OFS_COUNT_LOW: rd_mux = count_low_q;
		`OFS_COUNT_HIGH: rd_mux = count_high_buffer_q;
		`OFS_CONTROL_A: rd_mux = {control_reg_a_q[7], 1'b0, timer_output_q, control_reg_a_q[4:0]};
		`OFS_CONTROL_B: rd_mux = control_reg_b_q;
		`OFS_STATUS: rd_mux = {7'h00, timer_event_flag_q};
		default: rd_mux = 8'h00;
	endcase
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		reg_rdata_q <= 8'h00;
	end else if (reg_rd) begin
		reg_rdata_q <= rd_mux;
	end else begin
		reg_rdata_q <= 8'h00;
	end
end

endmodule

// ==== tb/timer_counter_asserts.sv ====
/*
 Port checker for the timer/counter.
 Assumes it is bound to timer_counter, one clock, reset high.
*/
`include "timer_counter_regs.vh"
module timer_counter_asserts #(
	parameter PRE_W = 15,
	parameter AUX_N = 5
) (
	// Clock
	input wire clk_sys,
	input wire rst,
	// Bus
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	// Inputs
	input wire count_pin,
	input wire [AUX_N-1:0] aux_clk_in,
	input wire sleep,
	// Outputs
	input wire timer_output_q,
	input wire period_pulse_q,
	input wire timer_event_flag_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire st_clr = reg_wr && reg_addr == `OFS_STATUS && reg_wdata[`ST_FLAG_BIT];
	wire dis_wr = reg_wr && reg_addr == `OFS_CONTROL_A && !reg_wdata[`CA_ENABLE_BIT];
	wire ca_rd = reg_rd && reg_addr == `OFS_CONTROL_A;
////////////////////////////////////////////////////////////
	AST_RESET_CLEAN: assert property ($fell(rst) |-> !timer_output_q && !timer_event_flag_q)
		else $error("outputs set after reset");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside read cycle");
	AST_CA_READ: assert property ($past(ca_rd) |-> reg_rdata_q[`CA_OUTPUT_BIT] == $past(timer_output_q))
		else $error("output bit not readable");
	AST_TOGGLE_FLAG: assert property ($changed(timer_output_q) |-> timer_event_flag_q)
		else $error("output toggled without event");
	AST_PULSE_TOGGLE: assert property ($rose(period_pulse_q) |-> $changed(timer_output_q))
		else $error("pulse without output toggle");
	AST_FLAG_CLR: assert property (st_clr |=> timer_event_flag_q == $changed(timer_output_q))
		else $error("flag clear wrong");
	AST_FLAG_STICKY: assert property (timer_event_flag_q && !st_clr |=> timer_event_flag_q)
		else $error("flag dropped");
	AST_DISABLE_QUIET: assert property (dis_wr |-> ##2 $stable(timer_output_q) [*6])
		else $error("event while disabled");
	cover property ($rose(period_pulse_q));
	cover property (st_clr);
	cover property ($fell(timer_output_q));
endmodule

// ==== tb/count_source_model.sv ====
/*
 Far-side count sources: external pin and auxiliary clocks.
 Assumes the bench calls pulse_out once the block is set up.
*/
module count_source_model (
	// Sources
	output logic count_pin,
	output logic [4:0] aux_clk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle low between bursts, never free running
	initial begin
		count_pin = 1'b0;
		aux_clk_in = 5'h00;
	end
	// 50 ns levels: above two cycles each, slower than sysclk/4
	task automatic pulse_out(input int n, input int sel);
		// Offset keeps pin changes away from the sampling edge
		#2;
		repeat (n) begin
			#50;
			if (sel == 0) count_pin = 1'b1;
			else aux_clk_in[sel-1] = 1'b1;
			#50;
			if (sel == 0) count_pin = 1'b0;
			else aux_clk_in[sel-1] = 1'b0;
		end
	endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for the timer/counter.
 Assumes design, header and partner model compiled first.
*/
`include "timer_counter_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep = 1'b0;
	logic [7:0] reg_rdata_q;
	logic count_pin;
	logic [4:0] aux_clk_in;
	logic timer_output_q, period_pulse_q, timer_event_flag_q;
	int miscompares = 0;
	int n_compared = 0;
	int n;
	// Bit 11 write, 10:8 offset, 7:0 data or expected
	logic [11:0] rows [16] = '{12'h000, 12'h1FF, 12'h200, 12'h300, 12'h400, 12'h500, 12'hD55, 12'h500,
		12'h95A, 12'h15A, 12'h833, 12'h033, 12'hA40, 12'h200, 12'hBA5, 12'h3A5};
	// Control b, control a, cycles between events at period 3
	logic [23:0] gaps [5] = '{24'h508010, 24'h528040, 24'h408010, 24'h508120, 24'h518020};
	always #5 clk_sys = ~clk_sys;
	timer_counter dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .count_pin(count_pin),
		.aux_clk_in(aux_clk_in), .sleep(sleep), .timer_output_q(timer_output_q),
		.period_pulse_q(period_pulse_q), .timer_event_flag_q(timer_event_flag_q));
	count_source_model src_u (.count_pin(count_pin), .aux_clk_in(aux_clk_in));
////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Gap cycle after each strobe so no signal is driven twice in one step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("read", reg_rdata_q, e);
		@(posedge clk_sys);
	endtask
	task automatic rise(output int k);
		k = 0;
		// Look after the edge has settled, not in the launching step
		while (period_pulse_q !== 1'b0 && k < 9000) begin @(posedge clk_sys); #1; k++; end
		while (period_pulse_q !== 1'b1 && k < 9000) begin @(posedge clk_sys); #1; k++; end
		if (k >= 9000) miscompares++;
	endtask
	task automatic stop_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			if (rows[i][11]) wr(rows[i][10:8], rows[i][7:0]);
			else rd(rows[i][10:8], rows[i][7:0]);
		end
		foreach (gaps[i]) begin
			wr(`OFS_CONTROL_A, 8'h00);
			wr(`OFS_COUNT_HIGH, 8'h03);
			wr(`OFS_CONTROL_B, gaps[i][23:16]);
			wr(`OFS_COUNT_LOW, 8'hFF);
			wr(`OFS_CONTROL_A, gaps[i][15:8]);
			rise(n);
			rise(n);
			chk("gap", n[7:0], gaps[i][7:0]);
		end
		// 16-bit: buffered high byte
		wr(`OFS_CONTROL_A, 8'h10);
		wr(`OFS_COUNT_HIGH, 8'h12);
		wr(`OFS_COUNT_LOW, 8'h34);
		wr(`OFS_COUNT_HIGH, 8'hAB);
		rd(`OFS_COUNT_HIGH, 8'hAB);
		rd(`OFS_COUNT_LOW, 8'h34);
		rd(`OFS_COUNT_HIGH, 8'h12);
		wr(`OFS_CONTROL_B, 8'h50);
		wr(`OFS_COUNT_HIGH, 8'hFF);
		wr(`OFS_COUNT_LOW, 8'hFE);
		wr(`OFS_STATUS, 8'h01);
		wr(`OFS_CONTROL_A, 8'h90);
		// Align to the rollover tick, then allow exactly seven more ticks
		rise(n);
		repeat (28) @(posedge clk_sys);
		wr(`OFS_CONTROL_A, 8'h10);
		rd(`OFS_STATUS, 8'h01);
		rd(`OFS_COUNT_LOW, 8'h07);
		rd(`OFS_COUNT_HIGH, 8'h00);
		// Counter mode on pin and aux clock
		wr(`OFS_CONTROL_B, 8'h10);
		wr(`OFS_COUNT_LOW, 8'h00);
		wr(`OFS_CONTROL_A, 8'h90);
		src_u.pulse_out(5, 0);
		repeat (8) @(posedge clk_sys);
		rd(`OFS_COUNT_LOW, 8'h05);
		sleep <= 1'b1;
		wr(`OFS_CONTROL_B, 8'h70);
		wr(`OFS_COUNT_LOW, 8'h00);
		src_u.pulse_out(3, 1);
		repeat (8) @(posedge clk_sys);
		rd(`OFS_COUNT_LOW, 8'h03);
		wr(`OFS_CONTROL_B, 8'h60);
		wr(`OFS_COUNT_LOW, 8'h00);
		src_u.pulse_out(3, 1);
		repeat (8) @(posedge clk_sys);
		rd(`OFS_COUNT_LOW, 8'h00);
		sleep <= 1'b0;
		wr(`OFS_CONTROL_A, 8'h10);
		wr(`OFS_CONTROL_B, 8'h10);
		wr(`OFS_COUNT_LOW, 8'h07);
		src_u.pulse_out(3, 0);
		repeat (8) @(posedge clk_sys);
		rd(`OFS_COUNT_LOW, 8'h07);
		wr(`OFS_STATUS, 8'h01);
		rd(`OFS_STATUS, 8'h00);
		stop_test();
	end
	// Whole run needs well under this
	initial begin
		#500000;
		miscompares++;
		stop_test();
	end
endmodule
bind timer_counter timer_counter_asserts #(.PRE_W(PRE_W), .AUX_N(AUX_N)) chk_u (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.count_pin(count_pin), .aux_clk_in(aux_clk_in), .sleep(sleep), .timer_output_q(timer_output_q),
	.period_pulse_q(period_pulse_q), .timer_event_flag_q(timer_event_flag_q));
